// File: logic/bmc_cfg.svh
// Offsets, field positions, reset values and timing for the broadcast block
`ifndef BMC_CFG_SVH
`define BMC_CFG_SVH

// Register indices; the byte address is four times the index
`define BMC_IDX_PERIODIC 16'h1402
`define BMC_IDX_SYNC 16'h1403
`define BMC_IDX_CELL_LOW 16'h1408
`define BMC_IDX_CELL_HIGH 16'h1409
// Status register index (read-only shadow of the primary copy)
`define BMC_IDX_STATUS 16'h1410
`define BMC_IDX_SEL_STATUS 16'h1411

`define BMC_PER_SEL_BIT 12
`define BMC_PER_LEN_MSB 8
`define BMC_PER_LEN_RST 9'h010
`define BMC_SYNC_PAUSE_BIT 15
`define BMC_SYNC_CNT_MSB 14
`define BMC_SYNC_CNT_LSB 10
`define BMC_SYNC_CNT_RST 5'h1F
`define BMC_SYNC_FAST_BIT 1
`define BMC_SYNC_CYC_BIT 0
`define BMC_CELL_HIGH_MSB 1
`define BMC_DUMMY_PULSE_CYCLES 1

`endif

// File: logic/bmc_pkg.sv
// Types shared by the broadcast block
package bmc_pkg;
  typedef enum logic [2:0] {
    BMC_TGT_NONE,
    BMC_TGT_PERIODIC,
    BMC_TGT_SYNC,
    BMC_TGT_CELL_LOW,
    BMC_TGT_CELL_HIGH,
    BMC_TGT_STATUS
  } bmc_target_t;

  typedef enum logic {
    BMC_BUS_IDLE,
    BMC_BUS_ACK
  } bmc_bus_state_t;
endpackage

// File: logic/bmc_unit_copy.sv
// One measurement unit's configuration copy, loaded by broadcast strobes
`timescale 1ns/100ps
`include "bmc_cfg.svh"

module bmc_unit_copy #(
  parameter int CELLS = 18,
  parameter bit HAS_SECONDARY = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_periodic,
  input wire logic wr_sync,
  input wire logic wr_cell_low,
  input wire logic wr_cell_high,
  input wire logic [15:0] wdata,
  output logic periodic_control_sel,
  output logic [8:0] periodic_interval_length,
  output logic balancing_pause_flag,
  output logic [4:0] secondary_channel_count,
  output logic fast_cycle,
  output logic synchronous_cycle_setting,
  output logic [CELLS-1:0] cell_enable
);
  initial begin
    if (CELLS != 18) $error("bmc_unit_copy serves 18 cells only");
  end

  logic next_sel;
  logic [8:0] next_len;
  logic next_pause;
  logic [4:0] next_cnt;
  logic next_fast;
  logic next_cyc;
  logic [CELLS-1:0] next_cells;

  always_comb begin
    next_sel = periodic_control_sel;
    next_len = periodic_interval_length;
    next_pause = balancing_pause_flag;
    next_cnt = secondary_channel_count;
    next_fast = 1'b0;
    next_cyc = synchronous_cycle_setting;
    next_cells = cell_enable;
    if (wr_periodic) begin
      next_sel = wdata[`BMC_PER_SEL_BIT];
      next_len = wdata[`BMC_PER_LEN_MSB:0];
    end
    if (wr_sync) begin
      next_pause = wdata[`BMC_SYNC_PAUSE_BIT];
      next_cyc = wdata[`BMC_SYNC_CYC_BIT];
      if (HAS_SECONDARY) begin
        next_cnt = wdata[`BMC_SYNC_CNT_MSB:`BMC_SYNC_CNT_LSB];
      end
    end
    if (HAS_SECONDARY) begin
      // Secondary keeps the fast-cycle setting as a level
      next_fast = wr_sync ? wdata[`BMC_SYNC_FAST_BIT] : fast_cycle;
    end else begin
      // Primary only sees a one-cycle dummy fast-cycle request
      next_fast = wr_sync & wdata[`BMC_SYNC_FAST_BIT];
    end
    if (wr_cell_low) begin
      next_cells[15:0] = wdata;
    end
    if (wr_cell_high) begin
      next_cells[17:16] = wdata[`BMC_CELL_HIGH_MSB:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_control_sel <= 1'b0;
      periodic_interval_length <= `BMC_PER_LEN_RST;
      balancing_pause_flag <= 1'b0;
      secondary_channel_count <= `BMC_SYNC_CNT_RST;
      fast_cycle <= 1'b0;
      synchronous_cycle_setting <= 1'b0;
      cell_enable <= '0;
    end else if (ce) begin
      periodic_control_sel <= next_sel;
      periodic_interval_length <= next_len;
      balancing_pause_flag <= next_pause;
      secondary_channel_count <= next_cnt;
      fast_cycle <= next_fast;
      synchronous_cycle_setting <= next_cyc;
      cell_enable <= next_cells;
    end
  end
endmodule

// File: logic/bmc_regs.sv
// Broadcast measurement control registers behind a Wishbone slave
`timescale 1ns/100ps
`include "bmc_cfg.svh"

// Overview of operation
// - Indices 1402h, 1403h, 1408h and 1409h decode as 16-bit write-only broadcast registers.
// - Bit 12 of the periodic register writes the control selector into both units, reset zero.
// - Bits 8:0 of the periodic register write the interval length into both units, reset 10h.
// - Bit 15 of the sync register writes the balancing pause flag into both units, reset zero.
// - Bits 14:10 of the sync register write the channel count into the secondary unit only, reset 1Fh.
// - Bit 1 of the sync register sets secondary fast cycle and gives the primary only a dummy pulse.
// - Bit 0 of the sync register writes the synchronous cycle setting into both units, reset zero.
// - Bit n of the low cell register writes cell n enable in both units together, reset zero.
// - Bits 1 and 0 of the high cell register write cells 17 and 16 in both units, reset zero.
// - Reserved bits read as zero and ignore written values.
module bmc_regs #(
  parameter int CELLS = 18
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic primary_periodic_control_sel,
  output logic [8:0] primary_periodic_interval_length,
  output logic primary_balancing_pause_flag,
  output logic primary_dummy_fast_cycle,
  output logic primary_synchronous_cycle_setting,
  output logic [CELLS-1:0] primary_cell_enable,
  output logic secondary_periodic_control_sel,
  output logic [8:0] secondary_periodic_interval_length,
  output logic secondary_balancing_pause_flag,
  output logic [4:0] secondary_channel_count,
  output logic secondary_fast_cycle,
  output logic secondary_synchronous_cycle_setting,
  output logic [CELLS-1:0] secondary_cell_enable
);
  initial begin
    if (CELLS != 18) $error("bmc_regs serves 18 cells only");
  end

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic bmc_pkg::bmc_target_t decode(input logic [17:0] adr);
    logic [15:0] idx;
    idx = adr[17:2];
    if (adr[1:0] != 2'h0) begin
      decode = bmc_pkg::BMC_TGT_NONE;
    end else if (idx == `BMC_IDX_PERIODIC) begin
      decode = bmc_pkg::BMC_TGT_PERIODIC;
    end else if (idx == `BMC_IDX_SYNC) begin
      decode = bmc_pkg::BMC_TGT_SYNC;
    end else if (idx == `BMC_IDX_CELL_LOW) begin
      decode = bmc_pkg::BMC_TGT_CELL_LOW;
    end else if (idx == `BMC_IDX_CELL_HIGH) begin
      decode = bmc_pkg::BMC_TGT_CELL_HIGH;
    end else if (idx == `BMC_IDX_STATUS) begin
      decode = bmc_pkg::BMC_TGT_STATUS;
    end else begin
      decode = bmc_pkg::BMC_TGT_NONE;
    end
  endfunction

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  bmc_pkg::bmc_bus_state_t state;
  bmc_pkg::bmc_bus_state_t next_state;
  logic next_ack;
  logic next_err;
  logic [31:0] next_dat;
  logic wr_periodic;
  logic wr_sync;
  logic wr_cell_low;
  logic wr_cell_high;
  logic [15:0] wdata;
  bmc_pkg::bmc_target_t tgt;
  logic lanes_ok;
  logic take;

  assign tgt = decode(wb_adr_i);
  // Registers are 16 bits wide: writes must select both low byte lanes
  assign lanes_ok = wb_sel_i[1:0] == 2'h3;
  assign take = wb_cyc_i & wb_stb_i & (state == bmc_pkg::BMC_BUS_IDLE);
  assign wdata = wb_dat_i[15:0];

  always_comb begin
    next_state = bmc_pkg::BMC_BUS_IDLE;
    next_ack = 1'b0;
    next_err = 1'b0;
    next_dat = 32'h0000_0000;
    wr_periodic = 1'b0;
    wr_sync = 1'b0;
    wr_cell_low = 1'b0;
    wr_cell_high = 1'b0;
    if (take) begin
      next_state = bmc_pkg::BMC_BUS_ACK;
      unique case (tgt)
        bmc_pkg::BMC_TGT_PERIODIC,
        bmc_pkg::BMC_TGT_SYNC,
        bmc_pkg::BMC_TGT_CELL_LOW,
        bmc_pkg::BMC_TGT_CELL_HIGH: begin
          // Write-only: reads return zero, partial-lane writes are refused
          if (wb_we_i && lanes_ok) begin
            next_ack = 1'b1;
            wr_periodic = tgt == bmc_pkg::BMC_TGT_PERIODIC;
            wr_sync = tgt == bmc_pkg::BMC_TGT_SYNC;
            wr_cell_low = tgt == bmc_pkg::BMC_TGT_CELL_LOW;
            wr_cell_high = tgt == bmc_pkg::BMC_TGT_CELL_HIGH;
          end else if (!wb_we_i) begin
            next_ack = 1'b1;
          end else begin
            next_err = 1'b1;
          end
        end
        bmc_pkg::BMC_TGT_STATUS: begin
          // Read-only view of the primary copy's loaded state
          if (!wb_we_i) begin
            next_ack = 1'b1;
            next_dat[8:0] = primary_periodic_interval_length;
            next_dat[12] = primary_periodic_control_sel;
            next_dat[13] = primary_synchronous_cycle_setting;
            next_dat[14] = primary_balancing_pause_flag;
            // Only cells 0 to 16 fit above the flags
            next_dat[31:15] = primary_cell_enable[16:0];
          end else begin
            next_err = 1'b1;
          end
        end
        bmc_pkg::BMC_TGT_NONE: begin
          next_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= bmc_pkg::BMC_BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      state <= next_state;
      wb_ack_o <= next_ack;
      wb_err_o <= next_err;
      wb_dat_o <= next_dat;
    end
  end

  // ---------------------------------------------------------------
  // Unit copies
  // ---------------------------------------------------------------
  // Both copies see the same strobes and data on the same edge, so
  // the units can never disagree part way through an update.
  logic [4:0] primary_unused_count;

  bmc_unit_copy #(
    .CELLS(CELLS),
    .HAS_SECONDARY(1'b0)
  ) u_primary (
    .clk(clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .wr_periodic(wr_periodic),
    .wr_sync(wr_sync),
    .wr_cell_low(wr_cell_low),
    .wr_cell_high(wr_cell_high),
    .wdata(wdata),
    .periodic_control_sel(primary_periodic_control_sel),
    .periodic_interval_length(primary_periodic_interval_length),
    .balancing_pause_flag(primary_balancing_pause_flag),
    .secondary_channel_count(primary_unused_count),
    .fast_cycle(primary_dummy_fast_cycle),
    .synchronous_cycle_setting(primary_synchronous_cycle_setting),
    .cell_enable(primary_cell_enable)
  );

  bmc_unit_copy #(
    .CELLS(CELLS),
    .HAS_SECONDARY(1'b1)
  ) u_secondary (
    .clk(clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .wr_periodic(wr_periodic),
    .wr_sync(wr_sync),
    .wr_cell_low(wr_cell_low),
    .wr_cell_high(wr_cell_high),
    .wdata(wdata),
    .periodic_control_sel(secondary_periodic_control_sel),
    .periodic_interval_length(secondary_periodic_interval_length),
    .balancing_pause_flag(secondary_balancing_pause_flag),
    .secondary_channel_count(secondary_channel_count),
    .fast_cycle(secondary_fast_cycle),
    .synchronous_cycle_setting(secondary_synchronous_cycle_setting),
    .cell_enable(secondary_cell_enable)
  );
endmodule

// File: sim/bmc_regs_monitor.sv
// Port-level assertions for the broadcast register block
`timescale 1ns/100ps
`include "bmc_cfg.svh"
module bmc_regs_monitor #(
  parameter int CELLS = 18
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic primary_periodic_control_sel,
  input wire logic [8:0] primary_periodic_interval_length,
  input wire logic primary_balancing_pause_flag,
  input wire logic primary_dummy_fast_cycle,
  input wire logic primary_synchronous_cycle_setting,
  input wire logic [CELLS-1:0] primary_cell_enable,
  input wire logic secondary_periodic_control_sel,
  input wire logic [8:0] secondary_periodic_interval_length,
  input wire logic secondary_balancing_pause_flag,
  input wire logic [4:0] secondary_channel_count,
  input wire logic secondary_fast_cycle,
  input wire logic secondary_synchronous_cycle_setting,
  input wire logic [CELLS-1:0] secondary_cell_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wr;
  logic [15:0] idx;
  assign wr = wb_ack_o && wb_we_i;
  assign idx = wb_adr_i[17:2];
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_answer_time: assert property ($rose(wb_stb_i) && wb_cyc_i && clk_en
    |=> wb_ack_o || wb_err_o) else $error("no answer after request");
  a_units_agree: assert property (primary_cell_enable == secondary_cell_enable
    && primary_periodic_interval_length == secondary_periodic_interval_length
    && primary_periodic_control_sel == secondary_periodic_control_sel
    && primary_balancing_pause_flag == secondary_balancing_pause_flag
    && primary_synchronous_cycle_setting == secondary_synchronous_cycle_setting
    ) else $error("unit copies differ");
  a_len_write: assert property (wr && idx == `BMC_IDX_PERIODIC |->
    primary_periodic_interval_length == wb_dat_i[8:0] &&
    primary_periodic_control_sel == wb_dat_i[12])
    else $error("periodic write not applied");
  a_count_write: assert property (wr && idx == `BMC_IDX_SYNC |->
    secondary_channel_count == wb_dat_i[14:10] &&
    secondary_fast_cycle == wb_dat_i[1] &&
    primary_balancing_pause_flag == wb_dat_i[15] &&
    primary_synchronous_cycle_setting == wb_dat_i[0])
    else $error("sync write not applied");
  a_dummy_pulse: assert property (primary_dummy_fast_cycle |->
    $past(wb_we_i) == 1'b1 ##1 !primary_dummy_fast_cycle)
    else $error("dummy pulse malformed");
  a_dummy_cause: assert property (wr && idx == `BMC_IDX_SYNC |->
    primary_dummy_fast_cycle == wb_dat_i[1])
    else $error("dummy pulse missing");
  a_cell_write: assert property (wr && idx == `BMC_IDX_CELL_LOW |->
    primary_cell_enable[15:0] == wb_dat_i[15:0])
    else $error("low cell write not applied");
  a_cell_high: assert property (wr && idx == `BMC_IDX_CELL_HIGH |->
    primary_cell_enable[17:16] == wb_dat_i[1:0])
    else $error("high cell write not applied");
  a_read_zero: assert property (wb_ack_o && !wb_we_i && idx inside
    {`BMC_IDX_PERIODIC, `BMC_IDX_SYNC, `BMC_IDX_CELL_LOW, `BMC_IDX_CELL_HIGH}
    |-> wb_dat_o == 32'h0000_0000) else $error("write-only reg read");
  a_cfg_hold: assert property (!wb_ack_o |-> $stable(secondary_cell_enable)
    && $stable(secondary_channel_count)
    && $stable(primary_periodic_interval_length))
    else $error("config changed without write");
endmodule

// File: sim/bmc_regs_tb.sv
// Self-checking bench for the broadcast register block
`timescale 1ns/100ps
`include "bmc_cfg.svh"
module bmc_regs_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [17:0] wb_adr_i = 18'h0_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wb_err_o;
  logic primary_periodic_control_sel, secondary_periodic_control_sel;
  logic [8:0] primary_periodic_interval_length;
  logic [8:0] secondary_periodic_interval_length;
  logic primary_balancing_pause_flag, secondary_balancing_pause_flag;
  logic primary_dummy_fast_cycle, secondary_fast_cycle;
  logic primary_synchronous_cycle_setting;
  logic secondary_synchronous_cycle_setting;
  logic [4:0] secondary_channel_count;
  logic [17:0] primary_cell_enable, secondary_cell_enable;
  int errors = 0;
  int n_compared = 0;
  logic [1:0] exp_q[$];
  // Expected model, starting at reset values
  logic [8:0] m_len = 9'h010;
  logic [4:0] m_cnt = 5'h1F;
  logic m_ps = 1'b0, m_pause = 1'b0, m_sc = 1'b0, m_fast = 1'b0;
  logic [17:0] m_cells = 18'h0_0000;
  logic [31:0] d;
  logic [15:0] regs[4] = '{`BMC_IDX_PERIODIC, `BMC_IDX_SYNC,
    `BMC_IDX_CELL_LOW, `BMC_IDX_CELL_HIGH};

  bmc_regs bmc_regs_inst (.*);
  always #50 clk = ~clk;

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [35:0] e,
    input logic [35:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // Read data of write-only places is always zero, so only flags are queued
  task automatic bus(input logic we, input logic [17:0] adr,
    input logic [3:0] sel, input logic err);
    int n;
    exp_q.push_back({!we, err});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= d;
    n = 0;
    // Look at the answer mid-cycle, where it has settled
    do begin
      @(negedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
      errors++;
      end_sim();
    end
    if (we && !err && adr[17:2] == `BMC_IDX_SYNC)
      cmp("dummy", {35'h0_0000_0000, d[1]},
        {35'h0_0000_0000, primary_dummy_fast_cycle});
    // Release at the edge where the answer is sampled high
    @(posedge clk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk();
    cmp("len", {m_len, m_len}, {primary_periodic_interval_length,
      secondary_periodic_interval_length});
    cmp("sel", {m_ps, m_ps}, {primary_periodic_control_sel,
      secondary_periodic_control_sel});
    cmp("pause", {m_pause, m_pause}, {primary_balancing_pause_flag,
      secondary_balancing_pause_flag});
    cmp("cycle", {m_sc, m_sc}, {primary_synchronous_cycle_setting,
      secondary_synchronous_cycle_setting});
    cmp("dummy idle", 36'h0_0000_0000,
      {35'h0_0000_0000, primary_dummy_fast_cycle});
    cmp("count", m_cnt, secondary_channel_count);
    cmp("fast", m_fast, secondary_fast_cycle);
    cmp("cells", {m_cells, m_cells},
      {primary_cell_enable, secondary_cell_enable});
  endtask

  always @(negedge clk) begin
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("ERROR answer expected none seen 1");
      end else begin
        cmp("wb_err_o", exp_q[0][0], wb_err_o);
        if (exp_q[0][1])
          cmp("wb_dat_o", 36'h0_0000_0000, wb_dat_o);
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    void'($urandom(62));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk();
    $display("test reset values done");
    // Random writes one at a time with idle cycles between them, reserved bits set at random too
    for (int i = 0; i < 32; i++) begin
      d = $urandom();
      bus(1'b1, {regs[i % 4], 2'b00}, 4'hF, 1'b0);
      case (i % 4)
        0: {m_ps, m_len} = {d[12], d[8:0]};
        1: {m_pause, m_cnt, m_fast, m_sc} = {d[15:10], d[1:0]};
        2: m_cells[15:0] = d[15:0];
        default: m_cells[17:16] = d[1:0];
      endcase
      chk();
    end
    $display("test broadcast writes done");
    d = 32'hFFFF_FFFF;
    bus(1'b1, {`BMC_IDX_STATUS, 2'b00}, 4'hF, 1'b1);
    bus(1'b1, {`BMC_IDX_SEL_STATUS, 2'b00}, 4'hF, 1'b1);
    bus(1'b1, {`BMC_IDX_SYNC, 2'b00}, 4'hC, 1'b1);
    bus(1'b1, {`BMC_IDX_PERIODIC, 2'b01}, 4'hF, 1'b1);
    for (int i = 0; i < 4; i++)
      bus(1'b0, {regs[i], 2'b00}, 4'hF, 1'b0);
    chk();
    $display("test refusals and reads done");
    end_sim();
  end
endmodule

bind bmc_regs bmc_regs_monitor #(.CELLS(CELLS)) bmc_regs_monitor_inst (.*);
